// ===== rtl/tvi_tx_desc_vlan.sv
// How it works
// [R1] tag enable set: put 0x8100 after source address
// [R2] then two tag bytes: four bytes added
// [R3] tag enable clear: frame passes unchanged
// [R4] host puts tag in word one bits 15:0
// [R5] vlan id split: high nibble, low byte
// [R6] three priority bits plus one format bit
// [R7] buffer address low from word two
// [R8] buffer address high from word three
// [R9] act only on owned, non large-send descriptors
// [R10] tag bits: id low, priority, format, id high
// [R11] clear ownership bit after frame sent
// [R12] end-of-ring descriptor wraps index to zero
// [R13] pass ip, udp, tcp sum requests on

`include "tvi_defines.svh"

// byte fifo between the buffer fetch and the tag inserter
module tvi_fifo #(
    parameter int WIDTH = 9,
    parameter int DEPTH = 16
) (
    input wire logic clock,
    input wire logic reset,
    input wire logic [WIDTH-1:0] wr_data,
    input wire logic wr_valid,
    output logic wr_ready,
    output logic [WIDTH-1:0] rd_data,
    output logic rd_valid,
    input wire logic rd_ready
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_r [DEPTH]; // storage words
    logic [AW:0] wr_ptr_r; // extra bit tells full from empty
    logic [AW:0] rd_ptr_r;
    wire full = (wr_ptr_r[AW] != rd_ptr_r[AW]) && (wr_ptr_r[AW-1:0] == rd_ptr_r[AW-1:0]);
    wire empty = (wr_ptr_r == rd_ptr_r);
    wire push = wr_valid && !full;
    wire pop = rd_ready && !empty;

    assign wr_ready = !full;
    assign rd_valid = !empty;
    assign rd_data = mem_r[rd_ptr_r[AW-1:0]];

    // storage has no reset: only written words are ever read
    always_ff @(posedge clock) begin
        if (push) begin
            mem_r[wr_ptr_r[AW-1:0]] <= wr_data;
        end
    end

    // pointer update
    always_ff @(posedge clock) begin
        if (reset) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
        end else begin
            if (push) begin
                wr_ptr_r <= wr_ptr_r + 1'b1;
            end
            if (pop) begin
                rd_ptr_r <= rd_ptr_r + 1'b1;
            end
        end
    end
endmodule : tvi_fifo

module tvi_tx_desc_vlan
    import tvi_pkg::*;
#(
    parameter int FIFO_DEPTH = 16
) (
    input wire logic clock,
    input wire logic reset,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    output logic mem_req,
    output logic mem_we,
    output logic [63:0] mem_addr,
    output logic [31:0] mem_wdata,
    input wire logic mem_ack,
    input wire logic [31:0] mem_rdata,
    output logic buf_req,
    output logic [63:0] buf_addr,
    output logic [15:0] buf_len,
    input wire logic buf_ack,
    input wire logic [7:0] in_data,
    input wire logic in_last,
    input wire logic in_valid,
    output logic in_ready,
    output logic [7:0] out_data,
    output logic out_last,
    output logic out_valid,
    input wire logic out_ready,
    output logic [2:0] out_sum_req
);
    // software registers
    logic [31:0] base_lo_r; // ring base, low word
    logic [31:0] base_hi_r; // ring base, high word
    logic run_r; // engine enabled
    logic err_r; // sticky: large-send descriptor met
    logic [31:0] sent_r; // frames completed
    logic [31:0] rdata_r;

    // engine state
    tvi_state_t st_r;
    tvi_state_t st_nxt;
    logic [15:0] idx_r; // current descriptor index
    logic [1:0] wcnt_r; // descriptor word being fetched
    logic [31:0] desc_r [4]; // fetched descriptor words
    logic [15:0] bcnt_r; // frame bytes taken from the fifo
    logic [2:0] ins_cnt_r; // inserted bytes already emitted: protocol id, then tag
    logic [7:0] out_data_r;
    logic out_last_r;
    logic out_valid_r;

    // descriptor fields
    wire own = desc_r[`TVI_DW_CMD][`TVI_OWN_BIT];
    wire ring_wrap_marker = desc_r[`TVI_DW_CMD][`TVI_WRAP_BIT];
    wire large_send_request = desc_r[`TVI_DW_CMD][`TVI_LGS_BIT];
    wire vlan_insert_enable = desc_r[`TVI_DW_TAG][`TVI_VIE_BIT];
    wire [15:0] tag_payload_field = desc_r[`TVI_DW_TAG][15:0]; // see [R4]
    // tag subfields, second wire byte first in memory
    wire [7:0] vlan_id_low_byte = tag_payload_field[`TVI_VID_LOW_MSB:`TVI_VID_LOW_LSB]; // see [R10]
    wire [3:0] vlan_id_high_nibble = tag_payload_field[`TVI_VID_HIGH_MSB:`TVI_VID_HIGH_LSB]; // see [R5]
    wire [2:0] user_priority_level = tag_payload_field[`TVI_PRIORITY_MSB:`TVI_PRIORITY_LSB]; // see [R6]
    wire canonical_format_flag = tag_payload_field[`TVI_FORMAT_BIT]; // see [R6]
    wire [11:0] vlan_id = {vlan_id_high_nibble, vlan_id_low_byte}; // see [R5]
    wire [31:0] buffer_address_low = desc_r[`TVI_DW_ADDR_LO]; // see [R7]
    wire [31:0] buffer_address_high = desc_r[`TVI_DW_ADDR_HI]; // see [R8]
    wire normal_desc = own && !large_send_request; // see [R9]

    // descriptor address: base plus sixteen bytes per index
    wire [63:0] desc_addr = {base_hi_r, base_lo_r} + ({48'h0000_0000_0000, idx_r} * `TVI_DESC_BYTES);

    // fifo hookup
    wire [8:0] fifo_rd_data;
    wire fifo_rd_valid;
    wire fifo_pop;
    tvi_fifo #(
        .WIDTH(9),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clock(clock),
        .reset(reset),
        .wr_data({in_last, in_data}),
        .wr_valid(in_valid),
        .wr_ready(in_ready),
        .rd_data(fifo_rd_data),
        .rd_valid(fifo_rd_valid),
        .rd_ready(fifo_pop)
    );

    // output stage may load when empty or being drained
    wire out_load_ok = (st_r == TVI_STREAM) && (!out_valid_r || out_ready);
    // insertion window sits right after the two addresses
    wire use_ins = vlan_insert_enable && (bcnt_r == `TVI_INSERT_POS) && (ins_cnt_r < `TVI_INSERT_LEN); // see [R1] [R3]
    wire load_ins = out_load_ok && use_ins;
    assign fifo_pop = out_load_ok && !use_ins && fifo_rd_valid;
    wire frame_done = fifo_pop && fifo_rd_data[8];

    // inserted byte selection: protocol id, then tag in wire order
    wire [7:0] ins_byte = (ins_cnt_r == 3'd0) ? `TVI_TPID_HI :
                          (ins_cnt_r == 3'd1) ? `TVI_TPID_LO :
                          (ins_cnt_r == 3'd2) ? tag_payload_field[7:0] : tag_payload_field[15:8]; // see [R1] [R2]

    // memory port: four reads per descriptor, one write to return it
    wire wb_go = (st_r == TVI_WRITEBACK) && !out_valid_r; // see [R11]
    assign mem_req = (st_r == TVI_FETCH) || wb_go;
    assign mem_we = wb_go;
    assign mem_addr = wb_go ? desc_addr : desc_addr + {60'h000_0000_0000_0000, wcnt_r, 2'b00};
    assign mem_wdata = {1'b0, desc_r[`TVI_DW_CMD][30:0]}; // see [R11]

    // buffer fetch request
    assign buf_req = (st_r == TVI_REQ_BUF);
    assign buf_addr = {buffer_address_high, buffer_address_low}; // see [R7] [R8]
    assign buf_len = desc_r[`TVI_DW_CMD][15:0];

    // frame stream outputs
    assign out_data = out_data_r;
    assign out_last = out_last_r;
    assign out_valid = out_valid_r;
    assign out_sum_req = {desc_r[`TVI_DW_CMD][`TVI_IP_SUM_BIT], desc_r[`TVI_DW_CMD][`TVI_UDP_SUM_BIT],
                          desc_r[`TVI_DW_CMD][`TVI_TCP_SUM_BIT]}; // see [R13]
    assign reg_rdata = rdata_r;

    // register decode
    wire wr_base_lo = reg_wr && (reg_addr == `TVI_REG_BASE_LO);
    wire wr_base_hi = reg_wr && (reg_addr == `TVI_REG_BASE_HI);
    wire wr_ctrl = reg_wr && (reg_addr == `TVI_REG_CTRL);
    wire wr_status = reg_wr && (reg_addr == `TVI_REG_STATUS);
    wire [31:0] status_word = {idx_r, 14'h0000, err_r, (st_r != TVI_IDLE)};
    wire [31:0] rd_mux = (reg_addr == `TVI_REG_BASE_LO) ? base_lo_r :
                         (reg_addr == `TVI_REG_BASE_HI) ? base_hi_r :
                         (reg_addr == `TVI_REG_CTRL) ? {31'h0000_0000, run_r} :
                         (reg_addr == `TVI_REG_STATUS) ? status_word :
                         (reg_addr == `TVI_REG_SENT) ? sent_r : `TVI_RST_WORD;
    wire halt = (st_r == TVI_CHECK) && own && large_send_request;

    // next-state logic
    always_comb begin
        st_nxt = st_r;
        case (st_r)
            TVI_IDLE: begin
                if (run_r) begin
                    st_nxt = TVI_FETCH;
                end
            end
            TVI_FETCH: begin
                if (mem_ack && (wcnt_r == 2'd3)) begin
                    st_nxt = TVI_CHECK;
                end
            end
            TVI_CHECK: begin
                // host-owned descriptor: ring is empty, poll again
                st_nxt = normal_desc ? TVI_REQ_BUF : TVI_IDLE; // see [R9]
            end
            TVI_REQ_BUF: begin
                if (buf_ack) begin
                    st_nxt = TVI_STREAM;
                end
            end
            TVI_STREAM: begin
                if (frame_done) begin
                    st_nxt = TVI_WRITEBACK;
                end
            end
            TVI_WRITEBACK: begin
                if (wb_go && mem_ack) begin
                    st_nxt = TVI_NEXT;
                end
            end
            TVI_NEXT: begin
                st_nxt = TVI_IDLE;
            end
            default: begin
                st_nxt = TVI_IDLE;
            end
        endcase
    end

    // state and fetch counter
    always_ff @(posedge clock) begin
        if (reset) begin
            st_r <= TVI_IDLE;
            wcnt_r <= 2'd0;
        end else begin
            st_r <= st_nxt;
            wcnt_r <= (st_r == TVI_FETCH && mem_ack) ? wcnt_r + 2'd1 : ((st_r == TVI_FETCH) ? wcnt_r : 2'd0);
        end
    end

    // descriptor index: wrap on end of ring, restart when the base low word is written
    always_ff @(posedge clock) begin
        if (reset || wr_base_lo) begin
            idx_r <= `TVI_RST_IDX;
        end else if (st_r == TVI_NEXT) begin
            idx_r <= ring_wrap_marker ? `TVI_RST_IDX : idx_r + 16'd1; // see [R12]
        end
    end

    // descriptor words captured as they arrive
    always_ff @(posedge clock) begin
        if (reset) begin
            for (int i = 0; i < 4; i++) begin
                desc_r[i] <= `TVI_RST_WORD;
            end
        end else if (st_r == TVI_FETCH && mem_ack) begin
            desc_r[wcnt_r] <= mem_rdata;
        end
    end

    // frame byte and insertion counters
    always_ff @(posedge clock) begin
        if (reset || st_r == TVI_REQ_BUF) begin
            bcnt_r <= 16'd0;
            ins_cnt_r <= 3'd0;
        end else begin
            if (fifo_pop && bcnt_r != 16'hFFFF) begin
                bcnt_r <= bcnt_r + 16'd1;
            end
            if (load_ins) begin
                ins_cnt_r <= ins_cnt_r + 3'd1; // see [R2]
            end
        end
    end

    // output register stage; frame is passed as is when no tag
    always_ff @(posedge clock) begin
        if (reset) begin
            out_data_r <= 8'h00;
            out_last_r <= 1'b0;
            out_valid_r <= 1'b0;
        end else if (load_ins) begin
            out_data_r <= ins_byte; // see [R1] [R2]
            out_last_r <= 1'b0;
            out_valid_r <= 1'b1;
        end else if (fifo_pop) begin
            out_data_r <= fifo_rd_data[7:0]; // see [R3]
            out_last_r <= fifo_rd_data[8];
            out_valid_r <= 1'b1;
        end else if (out_ready) begin
            out_valid_r <= 1'b0;
        end
    end

    // software registers; hardware error set wins over a clear
    always_ff @(posedge clock) begin
        if (reset) begin
            base_lo_r <= `TVI_RST_WORD;
            base_hi_r <= `TVI_RST_WORD;
            run_r <= 1'b0;
            err_r <= 1'b0;
            sent_r <= `TVI_RST_WORD;
            rdata_r <= `TVI_RST_WORD;
        end else begin
            if (wr_base_lo) begin
                base_lo_r <= reg_wdata;
            end
            if (wr_base_hi) begin
                base_hi_r <= reg_wdata;
            end
            // a large-send descriptor stops the engine; software restart wins
            if (wr_ctrl) begin
                run_r <= reg_wdata[`TVI_CTRL_RUN];
            end else if (halt) begin
                run_r <= 1'b0;
            end
            err_r <= halt || (err_r && !(wr_status && reg_wdata[`TVI_STAT_ERR]));
            if (st_r == TVI_NEXT) begin
                sent_r <= sent_r + 32'd1;
            end
            rdata_r <= reg_rd ? rd_mux : `TVI_RST_WORD;
        end
    end

    // checks
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (reset);

    sequence s_tpid;
        (out_valid_r && out_data_r == `TVI_TPID_HI) ##1 (out_valid_r && out_data_r == `TVI_TPID_LO)[*1];
    endsequence

    chk_tpid_first: assert property (load_ins && ins_cnt_r == 3'd0 |=> out_data_r == `TVI_TPID_HI) // see [R1]
        else $error("protocol id high byte wrong");
    chk_tpid_pair: assert property (load_ins && ins_cnt_r == 3'd0 ##1 (load_ins && ins_cnt_r == 3'd1) |-> ##1
        out_data_r == `TVI_TPID_LO) // see [R1]
        else $error("protocol id low byte wrong");
    chk_tag_order: assert property (load_ins && ins_cnt_r == 3'd3 |=> out_data_r == $past(tag_payload_field[15:8]))
        else $error("tag bytes out of wire order"); // see [R2]
    chk_no_tag_off: assert property (!vlan_insert_enable |-> !load_ins) // see [R3]
        else $error("tag inserted while disabled");
    chk_id_split: assert property (load_ins && ins_cnt_r == 3'd2 |=> out_data_r == {user_priority_level, canonical_format_flag, vlan_id[11:8]}) // see [R5]
        else $error("vlan id subfields misplaced");
    chk_buf_addr: assert property (buf_req |-> buf_addr == {desc_r[3], desc_r[2]}) // see [R7]
        else $error("buffer address not from words two and three");
    chk_owned_only: assert property (st_r == TVI_CHECK && !normal_desc |=> !buf_req) // see [R9]
        else $error("buffer fetched for foreign descriptor");
    chk_own_cleared: assert property (mem_req && mem_we |-> !mem_wdata[31] && mem_addr == desc_addr) // see [R11]
        else $error("descriptor returned without clearing ownership");
    chk_ring_wrap: assert property (st_r == TVI_NEXT && ring_wrap_marker |=> idx_r == `TVI_RST_IDX) // see [R12]
        else $error("end of ring did not wrap");
    chk_sum_flags: assert property (out_valid_r |-> out_sum_req == desc_r[0][18:16]) // see [R13]
        else $error("sum requests not passed on");
    chk_tpid_seq: assert property (load_ins && ins_cnt_r == 3'd0 ##1 out_ready |-> s_tpid) // see [R1]
        else $error("protocol id sequence broken");
endmodule : tvi_tx_desc_vlan

// ===== rtl/tvi_defines.svh
`ifndef TVI_DEFINES_SVH
`define TVI_DEFINES_SVH

// register offsets on the plain register port (byte addresses)
`define TVI_REG_BASE_LO 8'h00
`define TVI_REG_BASE_HI 8'h04
`define TVI_REG_CTRL 8'h08
`define TVI_REG_STATUS 8'h0C
`define TVI_REG_SENT 8'h10

// control and status bit positions
`define TVI_CTRL_RUN 0
`define TVI_STAT_BUSY 0
`define TVI_STAT_ERR 1
`define TVI_STAT_IDX_LSB 16

// descriptor layout: word index and bit positions
`define TVI_DW_CMD 2'd0
`define TVI_DW_TAG 2'd1
`define TVI_DW_ADDR_LO 2'd2
`define TVI_DW_ADDR_HI 2'd3
`define TVI_DESC_BYTES 64'h0000_0000_0000_0010
`define TVI_OWN_BIT 31
`define TVI_WRAP_BIT 30
`define TVI_LGS_BIT 27
`define TVI_IP_SUM_BIT 18
`define TVI_UDP_SUM_BIT 17
`define TVI_TCP_SUM_BIT 16
`define TVI_VIE_BIT 17

// tag field layout inside descriptor word 1
`define TVI_VID_LOW_MSB 15
`define TVI_VID_LOW_LSB 8
`define TVI_PRIORITY_MSB 7
`define TVI_PRIORITY_LSB 5
`define TVI_FORMAT_BIT 4
`define TVI_VID_HIGH_MSB 3
`define TVI_VID_HIGH_LSB 0

// inserted protocol identifier and where it goes in the frame
`define TVI_TPID_HI 8'h81
`define TVI_TPID_LO 8'h00
`define TVI_INSERT_POS 16'h000C
`define TVI_INSERT_LEN 3'h4

// reset values
`define TVI_RST_WORD 32'h0000_0000
`define TVI_RST_IDX 16'h0000

`endif

// ===== rtl/tvi_pkg.sv
package tvi_pkg;

    // descriptor engine states
    typedef enum logic [2:0] {
        TVI_IDLE,
        TVI_FETCH,
        TVI_CHECK,
        TVI_REQ_BUF,
        TVI_STREAM,
        TVI_WRITEBACK,
        TVI_NEXT
    } tvi_state_t;

endpackage : tvi_pkg

// ===== test/tvi_host_mem.sv
// host memory model: holds descriptor words, answers the engine late or at once
module tvi_host_mem (
    input wire logic clock,
    input wire logic mem_req,
    input wire logic mem_we,
    input wire logic [63:0] mem_addr,
    input wire logic [31:0] mem_wdata,
    output logic mem_ack,
    output logic [31:0] mem_rdata
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [31:0] mem [0:63]; // word store, the bench preloads descriptors here
    logic [1:0] wait_r; // cycles still to stall before the next ack
    initial begin
        mem_ack = 1'b0;
        mem_rdata = 32'h0000_0000;
        wait_r = 2'h0;
    end
    // one-cycle ack after a random stall; read data only valid beside the ack
    always @(posedge clock) begin
        mem_ack <= 1'b0;
        // outside the ack cycle the data lines flip so stale data never looks right
        mem_rdata <= ~mem_rdata;
        if (mem_req && !mem_ack) begin
            if (wait_r == 2'h0) begin
                mem_ack <= 1'b1;
                wait_r <= 2'($urandom % 3);
                if (mem_we) begin
                    mem[mem_addr[7:2]] <= mem_wdata;
                end else begin
                    mem_rdata <= mem[mem_addr[7:2]];
                end
            end else begin
                wait_r <= wait_r - 2'h1;
            end
        end
    end
endmodule : tvi_host_mem

// ===== test/tb.sv
// self-checking bench: register port, host memory model, frame source and sink
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock, reset, reg_wr, reg_rd, mem_req, mem_we, mem_ack, buf_req, buf_ack;
    logic in_last, in_valid, in_ready, out_last, out_valid, out_ready;
    logic [7:0] reg_addr, in_data, out_data;
    logic [31:0] reg_wdata, reg_rdata, mem_wdata, mem_rdata, rd;
    logic [63:0] mem_addr, buf_addr;
    logic [15:0] buf_len;
    logic [2:0] out_sum_req, exp_sum;
    logic [31:0] dw [0:11]; // descriptor words as the host built them
    logic [8:0] exp_q [$]; // expected {last, byte} in output order
    logic [8:0] e;
    logic stall, saw_full;
    int n_fail = 0, checks_done = 0, fidx = 0, cyc = 0;
    tvi_tx_desc_vlan #(.FIFO_DEPTH(16)) tvi_tx_desc_vlan_i (.clock(clock), .reset(reset), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .mem_req(mem_req),
        .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_ack(mem_ack), .mem_rdata(mem_rdata),
        .buf_req(buf_req), .buf_addr(buf_addr), .buf_len(buf_len), .buf_ack(buf_ack), .in_data(in_data),
        .in_last(in_last), .in_valid(in_valid), .in_ready(in_ready), .out_data(out_data), .out_last(out_last),
        .out_valid(out_valid), .out_ready(out_ready), .out_sum_req(out_sum_req));
    tvi_host_mem tvi_host_mem_i (.clock(clock), .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr),
        .mem_wdata(mem_wdata), .mem_ack(mem_ack), .mem_rdata(mem_rdata));
    initial begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end
    // the single comparison point; four-state compare so unknowns fail
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_fail++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic final_report;
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : final_report
    task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clock);
        reg_wr <= 1'b0;
    endtask : reg_write
    // read data stands only in the cycle after the strobe edge
    task automatic reg_read(input logic [7:0] a, output logic [31:0] d);
        @(posedge clock);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clock);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask : reg_read
    // hang guard: far above the few hundred cycles the run needs
    always @(posedge clock) begin
        cyc++;
        if (cyc == 20000) begin
            n_fail++;
            final_report();
        end
    end
    // sink: random back-pressure, plus a long stall until the fifo refuses
    always @(posedge clock) begin
        out_ready <= !stall && ($urandom % 4 != 0);
        if (in_valid && !in_ready) begin
            saw_full <= 1'b1;
            stall <= 1'b0;
        end
    end
    // output watcher takes the oldest note for each accepted byte
    always @(negedge clock) begin
        if (out_valid === 1'b1 && out_ready) begin
            e = exp_q.pop_front();
            check({23'h0, out_last, out_data}, {23'h0, e});
            check({29'h0, out_sum_req}, {29'h0, exp_sum});
        end
    end
    // buffer source: accepts a fetch request, notes the expected frame, streams it
    always begin
        @(negedge clock);
        if (buf_req === 1'b1) begin
            automatic int k = fidx * 4;
            automatic int len = dw[k][15:0];
            automatic logic [7:0] b;
            check(buf_addr[31:0], dw[k+2]);
            check(buf_addr[63:32], dw[k+3]);
            check({16'h0, buf_len}, {16'h0, dw[k][15:0]});
            exp_sum = dw[k][18:16];
            @(posedge clock);
            buf_ack <= 1'b1;
            @(posedge clock);
            buf_ack <= 1'b0;
            for (int i = 0; i < len; i++) begin
                b = 8'($urandom);
                // tag goes after the 12 address bytes: 0x8100 then the two tag bytes
                if (dw[k+1][17] && i == 12) begin
                    exp_q.push_back({1'b0, 8'h81});
                    exp_q.push_back({1'b0, 8'h00});
                    exp_q.push_back({1'b0, dw[k+1][7:0]});
                    exp_q.push_back({1'b0, dw[k+1][15:8]});
                end
                exp_q.push_back({i == len - 1, b});
                in_data <= b;
                in_last <= (i == len - 1);
                in_valid <= 1'b1;
                do @(negedge clock); while (in_ready !== 1'b1);
                @(posedge clock);
            end
            in_valid <= 1'b0;
            in_data <= ~in_data;
            fidx++;
        end
    end
    initial begin
        void'($urandom(90926));
        // source idle and sink stalled at start, so the fifo must fill before anything drains
        {reset, reg_wr, reg_rd, buf_ack, in_last, in_valid, out_ready, stall, saw_full} = 9'h1_02;
        reg_addr = 8'h00;
        reg_wdata = 32'h0000_0000;
        in_data = 8'h00;
        // host builds: owned normal tagged frame, owned untagged end-of-ring frame, large send
        dw[0] = 32'h8005_0014;
        dw[1] = 32'h0002_0000 | 32'($urandom % 32'h0001_0000);
        dw[4] = 32'hC002_0010;
        dw[5] = 32'($urandom % 32'h0001_0000);
        dw[8] = 32'h8800_0010;
        dw[9] = 32'h0000_0000;
        for (int i = 0; i < 12; i++) begin
            if (i % 4 >= 2) dw[i] = $urandom;
            tvi_host_mem_i.mem[i] = dw[i];
        end
        repeat (20) @(posedge clock);
        reset <= 1'b0;
        reg_read(`TVI_REG_STATUS, rd);
        check(rd, 32'h0000_0000);
        reg_read(`TVI_REG_SENT, rd);
        check(rd, 32'h0000_0000);
        reg_write(`TVI_REG_BASE_HI, 32'h0000_0000);
        reg_write(`TVI_REG_BASE_LO, 32'h0000_0000);
        reg_write(`TVI_REG_CTRL, 32'h0000_0001);
        for (int t = 0; t < 1000 && rd !== 32'h0000_0002; t++) reg_read(`TVI_REG_SENT, rd);
        check(rd, 32'h0000_0002);
        repeat (20) @(posedge clock);
        check(tvi_host_mem_i.mem[0], dw[0] & 32'h7FFF_FFFF);
        check(tvi_host_mem_i.mem[4], dw[4] & 32'h7FFF_FFFF);
        reg_read(`TVI_REG_STATUS, rd);
        check({16'h0, rd[31:16]}, 32'h0000_0000);
        check({31'h0, saw_full}, 32'h0000_0001);
        check(exp_q.size(), 32'h0000_0000);
        // large-send descriptor halts the engine with the error flag
        reg_write(`TVI_REG_CTRL, 32'h0000_0000);
        reg_write(`TVI_REG_BASE_LO, 32'h0000_0020);
        reg_write(`TVI_REG_CTRL, 32'h0000_0001);
        repeat (60) @(posedge clock);
        reg_read(`TVI_REG_STATUS, rd);
        check({31'h0, rd[1]}, 32'h0000_0001);
        reg_read(`TVI_REG_CTRL, rd);
        check(rd, 32'h0000_0000);
        reg_write(`TVI_REG_STATUS, 32'h0000_0002);
        reg_write(`TVI_REG_SENT, 32'h0000_0007);
        reg_read(`TVI_REG_STATUS, rd);
        check({31'h0, rd[1]}, 32'h0000_0000);
        reg_read(`TVI_REG_SENT, rd);
        check(rd, 32'h0000_0002);
        reg_read(8'h14, rd);
        check(rd, 32'h0000_0000);
        final_report();
    end
endmodule : tb
